// ==== src/embg_pkg.sv ====
// Shared constants and types of the external memory read and bus grant logic
package embg_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int WAIT_W = 3;
    localparam int CNT_W  = 5;
    localparam int LOCK_W = 16;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int REF_PERIOD_PS    = 4000;
    // One output clock period spans four reference clocks (quarters)
    localparam int OUT_PERIOD_PS    = 16000;
    localparam int QUARTERS         = OUT_PERIOD_PS / REF_PERIOD_PS;
    localparam int LOCK_INPUT_CYC   = 2000;
    localparam int LOCK_REF_CYCLES  = LOCK_INPUT_CYC * QUARTERS;

    localparam logic [1:0] Q_RISE   = 2'h0;
    localparam logic [1:0] Q_SAMPLE = 2'h1;
    localparam logic [1:0] Q_STROBE = 2'h1;
    localparam logic [1:0] Q_LAST   = 2'h3;

    // Read strobe: half period plus one period per wait state
    localparam logic [CNT_W-1:0] STRB_BASE_Q = 5'h02;
    localparam logic [CNT_W-1:0] WAIT_Q      = 5'h04;

    // ------------------------------------------------------------------
    // Memory spaces
    // ------------------------------------------------------------------
    localparam logic [1:0] SP_PROG = 2'h0;
    localparam logic [1:0] SP_DATA = 2'h1;
    localparam logic [1:0] SP_BOOT = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_STRB    = 3'b010,
        ST_HOLD    = 3'b011,
        ST_FLOAT   = 3'b100,
        ST_GRANT   = 3'b101,
        ST_RECLAIM = 3'b110
    } embg_state_t;

    function automatic logic [CNT_W-1:0] strobe_quarters(
        input logic [WAIT_W-1:0] waits);
        strobe_quarters = STRB_BASE_Q
                        + CNT_W'(WAIT_Q * {2'h0, waits});
    endfunction

endpackage

// ==== src/embg_req_sync.sv ====
// Bus request synchroniser and cycle-phase recognition
`timescale 1ns/10ps
module embg_req_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic req_async_n,
    input  wire logic sample,
    output logic      recognised
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic recog;
    } embg_sync_t;

    embg_sync_t s_r;
    embg_sync_t s_nxt;

    // [RULE_05] Two flops
    // Async request needs no outside synchroniser
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = ~req_async_n;
        s_nxt.s2 = s_r.s1;
        // [RULE_03] Phase sampling
        // Late request misses this sample, taken next cycle
        if (sample) begin
            s_nxt.recog = s_r.s2;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign recognised = s_r.recog;

    // [RULE_03] Sample point check
    chk_recog_sample: assert property (@(posedge ref_clk) disable iff (rst)
        sample |=> (recognised == $past(s_r.s2)))
        else $error("request not recognised at sample point");

    // [RULE_05] Recognition holds between samples
    chk_recog_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !sample |=> $stable(recognised))
        else $error("recognition changed outside sample point");

endmodule // embg_req_sync

// ==== src/embg_bus_ctrl.sv ====
// External memory read cycle, output clock and bus request/grant logic
// How it works
// [RULE_01] Reset held at least five input clock periods after power-up.
// [RULE_02] Clock multiplier locks within 2000 input cycles after reset.
// [RULE_03] Request meeting sample window is recognised this cycle, else next.
// [RULE_04] Grant goes low in the cycle after request recognition.
// [RULE_05] Asynchronous request accepted; device synchronises it internally.
// [RULE_06] Selects and strobes float just after output clock rising edge.
// [RULE_07] Selects and strobes float before grant goes low.
// [RULE_08] Selects and strobes driven again only after grant returns high.
// [RULE_09] Re-driven lines valid over a quarter period before next rise.
// [RULE_10] Read strobe falls in the second quarter after clock rise.
// [RULE_11] Address and select valid before read strobe falls.
// [RULE_12] Address and select held after read strobe rises.
// [RULE_13] Half period of strobe high before any strobe falls again.
// [RULE_14] Strobe lasts half period plus one period per wait state.
// [RULE_15] Memory returns valid data before the wait-extended deadline.
// [RULE_16] Grant kept while request stays; reclaimed after release is seen.
`timescale 1ns/10ps
module embg_bus_ctrl #(
    parameter int LOCK_REF_CYCLES = embg_pkg::LOCK_REF_CYCLES
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         bus_request_n,
    input  wire logic                         rd_req,
    output logic                              rd_ready,
    input  wire logic [1:0]                   rd_space,
    input  wire logic [embg_pkg::ADDR_W-1:0]  rd_addr,
    input  wire logic [embg_pkg::WAIT_W-1:0]  rd_wait,
    input  wire logic [embg_pkg::DATA_W-1:0]  rd_data_in,
    output logic [embg_pkg::DATA_W-1:0]       rd_data,
    output logic                              rd_done,
    output logic [embg_pkg::ADDR_W-1:0]       addr_out,
    output logic                              prog_mem_select_n,
    output logic                              data_mem_select_n,
    output logic                              boot_mem_select_n,
    output logic                              read_strobe_n,
    output logic                              write_strobe_n,
    output logic                              strobe_oe_n,
    output logic                              bus_grant_n,
    output logic                              processor_clock_out,
    output logic                              pll_locked
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        embg_pkg::embg_state_t             st;
        logic [1:0]                        q;
        logic [embg_pkg::LOCK_W-1:0]       lock_cnt;
        logic                              locked;
        logic [embg_pkg::CNT_W-1:0]        cnt;
        logic [embg_pkg::ADDR_W-1:0]       addr;
        logic [1:0]                        space;
        logic                              clk_out;
        logic                              rd_n;
        logic [2:0]                        sel_n;
        logic                              oe_n;
        logic                              grant_n;
        logic [embg_pkg::DATA_W-1:0]       data;
        logic                              done;
    } embg_ctrl_t;

    localparam logic [embg_pkg::LOCK_W-1:0] LOCK_LAST =
        embg_pkg::LOCK_W'(LOCK_REF_CYCLES - 1);

    embg_ctrl_t s_r;
    embg_ctrl_t s_nxt;
    logic       req_recog;
    logic       in_read;

    // ------------------------------------------------------------------
    // Request recognition
    // ------------------------------------------------------------------
    embg_req_sync u_req_sync (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .req_async_n (bus_request_n),
        .sample      (s_r.locked && s_r.q == embg_pkg::Q_SAMPLE),
        .recognised  (req_recog)
    );

    // Reads start only on the last quarter so the address lands on a rise
    assign rd_ready = s_r.locked && s_r.st == embg_pkg::ST_IDLE
                   && s_r.q == embg_pkg::Q_LAST && !req_recog;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        in_read    = 1'b0;
        // [RULE_02] Lock counter
        // No output clock and no bus cycles until lock
        if (!s_r.locked) begin
            s_nxt.q = embg_pkg::Q_RISE;
            if (s_r.lock_cnt == LOCK_LAST) begin
                s_nxt.locked = 1'b1;
            end else begin
                s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
            end
        end else begin
            s_nxt.q = s_r.q + 2'h1;
        end

        case (s_r.st)
            embg_pkg::ST_IDLE: begin
                // [RULE_13] Strobe gap
                // Start only at last quarter, so strobe high at least six quarters
                if (rd_req && rd_ready) begin
                    s_nxt.st    = embg_pkg::ST_SETUP;
                    s_nxt.addr  = rd_addr;
                    s_nxt.space = rd_space;
                    s_nxt.cnt   = embg_pkg::strobe_quarters(rd_wait);
                // [RULE_04] Grant next cycle
                // Float on the rise after recognition
                end else if (s_r.locked && s_r.q == embg_pkg::Q_LAST
                             && req_recog) begin
                    s_nxt.st = embg_pkg::ST_FLOAT;
                end
            end
            // [RULE_11] Address first
            // Address and select out one quarter before the strobe
            embg_pkg::ST_SETUP: begin
                s_nxt.st = embg_pkg::ST_STRB;
            end
            // [RULE_14] Strobe length
            // Data sampled in last low quarter; memory owns the deadline
            embg_pkg::ST_STRB: begin
                if (s_r.cnt == 5'h01) begin
                    s_nxt.st   = embg_pkg::ST_HOLD;
                    s_nxt.data = rd_data_in;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            // [RULE_12] Address hold
            embg_pkg::ST_HOLD: begin
                s_nxt.st = embg_pkg::ST_IDLE;
            end
            // [RULE_07] Float first
            embg_pkg::ST_FLOAT: begin
                s_nxt.st = embg_pkg::ST_GRANT;
            end
            // [RULE_16] Hold grant
            // Released only after a recognised deassertion
            embg_pkg::ST_GRANT: begin
                if (s_r.q == embg_pkg::Q_LAST && !req_recog) begin
                    s_nxt.st = embg_pkg::ST_RECLAIM;
                end
            end
            // [RULE_08] Grant high first
            // [RULE_09] Drive again at second quarter, well before rise
            embg_pkg::ST_RECLAIM: begin
                s_nxt.st = embg_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = embg_pkg::ST_IDLE;
            end
        endcase

        // Pins follow the next state so every pin comes from a flop
        in_read = s_nxt.st == embg_pkg::ST_SETUP
               || s_nxt.st == embg_pkg::ST_STRB
               || s_nxt.st == embg_pkg::ST_HOLD;
        // [RULE_10] Strobe second quarter
        s_nxt.rd_n     = s_nxt.st != embg_pkg::ST_STRB;
        s_nxt.sel_n[0] = !(in_read && s_nxt.space == embg_pkg::SP_PROG);
        s_nxt.sel_n[1] = !(in_read && s_nxt.space == embg_pkg::SP_DATA);
        s_nxt.sel_n[2] = !(in_read && s_nxt.space == embg_pkg::SP_BOOT);
        // [RULE_06] Float after rise
        s_nxt.oe_n     = s_nxt.st == embg_pkg::ST_FLOAT
                      || s_nxt.st == embg_pkg::ST_GRANT
                      || s_nxt.st == embg_pkg::ST_RECLAIM;
        s_nxt.grant_n  = s_nxt.st != embg_pkg::ST_GRANT;
        s_nxt.clk_out  = s_nxt.locked && !s_nxt.q[1];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.st      <= embg_pkg::ST_IDLE;
            s_r.rd_n    <= 1'b1;
            s_r.sel_n   <= 3'h7;
            s_r.grant_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data             = s_r.data;
    assign rd_done             = s_r.done;
    assign addr_out            = s_r.addr;
    assign prog_mem_select_n   = s_r.sel_n[0];
    assign data_mem_select_n   = s_r.sel_n[1];
    assign boot_mem_select_n   = s_r.sel_n[2];
    assign read_strobe_n       = s_r.rd_n;
    // Write cycles live elsewhere; strobe parked high, floats with the rest
    assign write_strobe_n      = 1'b1;
    assign strobe_oe_n         = s_r.oe_n;
    assign bus_grant_n         = s_r.grant_n;
    assign processor_clock_out = s_r.clk_out;
    assign pll_locked          = s_r.locked;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [embg_pkg::CNT_W-1:0] low_len_r;
    logic [embg_pkg::CNT_W-1:0] exp_len_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            low_len_r <= '0;
            exp_len_r <= '0;
        end else begin
            low_len_r <= read_strobe_n ? 5'h00 : low_len_r + 5'h01;
            if (rd_req && rd_ready) begin
                exp_len_r <= embg_pkg::strobe_quarters(rd_wait);
            end
        end
    end

    chk_lock_clock: assert property (@(posedge ref_clk) disable iff (rst)
        !pll_locked |-> !processor_clock_out && read_strobe_n) // [RULE_02]
        else $error("activity before lock");
    chk_grant_late: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(req_recog) |-> bus_grant_n [*3]) // [RULE_04]
        else $error("grant in recognition cycle");
    chk_float_rise: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(strobe_oe_n) |-> processor_clock_out
                               && s_r.q == embg_pkg::Q_RISE) // [RULE_06]
        else $error("float not just after clock rise");
    chk_float_grant: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(bus_grant_n) |-> strobe_oe_n && $past(strobe_oe_n)) // [RULE_07]
        else $error("grant before lines floated");
    chk_redrive_order: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(strobe_oe_n) |-> bus_grant_n && $past(bus_grant_n)) // [RULE_08]
        else $error("lines driven while granted");
    chk_redrive_early: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(strobe_oe_n) |-> s_r.q == embg_pkg::Q_STROBE) // [RULE_09]
        else $error("redrive too close to clock rise");
    chk_strobe_phase: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(read_strobe_n) |-> processor_clock_out
                                 && s_r.q == embg_pkg::Q_STROBE) // [RULE_10]
        else $error("read strobe outside second quarter");
    chk_addr_setup: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(read_strobe_n) |-> $stable(addr_out)
                                 && $stable(s_r.sel_n)
                                 && s_r.sel_n != 3'h7) // [RULE_11]
        else $error("address not set up before strobe");
    chk_addr_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(read_strobe_n) |-> s_r.sel_n != 3'h7
                                 ##1 $stable(addr_out)) // [RULE_12]
        else $error("address not held after strobe");
    chk_strobe_gap: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(read_strobe_n) |-> read_strobe_n [*2]) // [RULE_13]
        else $error("strobe gap too short");
    chk_strobe_len: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(read_strobe_n) |-> low_len_r == exp_len_r) // [RULE_14]
        else $error("read strobe length wrong");
    chk_grant_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (!bus_grant_n && req_recog) |=> !bus_grant_n) // [RULE_16]
        else $error("grant dropped while request held");

    cov_wait_read: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(read_strobe_n) && low_len_r > embg_pkg::STRB_BASE_Q);
    cov_grant: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(bus_grant_n));
    cov_reclaim: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(strobe_oe_n));

endmodule // embg_bus_ctrl

// ==== dv/embg_mem_model.sv ====
// External memory model that answers the device's read cycles
`timescale 1ns/10ps
module embg_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [2:0]  sel_n,
    input  wire logic        strobe_n,
    input  wire logic        oe_n,
    input  wire logic [13:0] addr,
    input  wire logic [2:0]  lag,
    output logic [23:0]      data
);
    logic [2:0]  low_cnt = 3'h0;
    logic [23:0] last    = 24'h0;
    logic        active;
    logic [1:0]  sp;

    assign active = !oe_n && !strobe_n && (sel_n != 3'h7);
    assign sp = !sel_n[0] ? 2'h0 : (!sel_n[1] ? 2'h1 : 2'h2);

    always_ff @(posedge ref_clk) begin
        if (!active) begin
            low_cnt <= 3'h0;
        end else if (low_cnt != 3'h7) begin
            low_cnt <= low_cnt + 3'h1;
        end
        last    <= data;
    end

    // Data after lag
    // Outside a read the bus toggles, so stale data never matches
    always_comb begin
        if (active && low_cnt >= lag) begin
            data = {6'h28, sp, 2'h0, addr};
        end else begin
            data = ~last;
        end
    end
endmodule // embg_mem_model

// ==== dv/test_ext_mem_read_bus_grant.sv ====
// Self-checking testbench of the external memory read and bus grant block
`timescale 1ns/10ps
module test_ext_mem_read_bus_grant;
    localparam int LOCK = 8;
    logic        ref_clk = 1'b0, rst = 1'b1, bus_request_n = 1'b1;
    logic        rd_req = 1'b0, rd_ready, rd_done, pll_locked;
    logic [1:0]  rd_space = 2'h0;
    logic [13:0] rd_addr = 14'h0, addr_out;
    logic [2:0]  rd_wait = 3'h0, lag = 3'h0, sel_n;
    logic [23:0] rd_data_in, rd_data;
    logic        pms_n, dms_n, bms_n, read_strobe_n, write_strobe_n;
    logic        strobe_oe_n, bus_grant_n, processor_clock_out;
    int          failures = 0, samples_checked = 0, cycles = 0;
    int          hi_run = 0, min_gap = 99;

    assign sel_n = {bms_n, dms_n, pms_n};

    embg_bus_ctrl #(.LOCK_REF_CYCLES(LOCK)) dut (
        .ref_clk(ref_clk), .rst(rst), .bus_request_n(bus_request_n),
        .rd_req(rd_req), .rd_ready(rd_ready), .rd_space(rd_space),
        .rd_addr(rd_addr), .rd_wait(rd_wait), .rd_data_in(rd_data_in),
        .rd_data(rd_data), .rd_done(rd_done), .addr_out(addr_out),
        .prog_mem_select_n(pms_n), .data_mem_select_n(dms_n),
        .boot_mem_select_n(bms_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .strobe_oe_n(strobe_oe_n),
        .bus_grant_n(bus_grant_n), .processor_clock_out(processor_clock_out),
        .pll_locked(pll_locked));

    embg_mem_model mem (
        .ref_clk(ref_clk), .sel_n(sel_n), .strobe_n(read_strobe_n),
        .oe_n(strobe_oe_n), .addr(addr_out), .lag(lag), .data(rd_data_in));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Monitors and shared tasks
    // ------------------------------------------------------------------
    // Strobe high gap sampled mid-cycle, away from edge updates
    always @(negedge ref_clk) begin
        if (rst || read_strobe_n) begin
            hi_run <= rst ? 0 : hi_run + 1;
        end else begin
            if (hi_run != 0 && hi_run < min_gap) min_gap <= hi_run;
            hi_run <= 0;
        end
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        int k;
        rst = 1'b1;
        // Reset width
        // Five input clock periods of four reference clocks each
        step(5 * embg_pkg::QUARTERS);
        check("grant_rst", bus_grant_n, 1);
        check("strobe_rst", {read_strobe_n, write_strobe_n, sel_n}, 5'h1f);
        check("oe_rst", strobe_oe_n, 0);
        rst = 1'b0;
        k = 0;
        while (pll_locked !== 1'b1 && k < 50) begin
            check("clk_prelock", processor_clock_out, 0);
            step(1);
            k++;
        end
        check("lock_time", k <= LOCK + 2, 1);
        $display("test reset done");
    endtask

    task automatic t_read(input logic [1:0] sp, input logic [13:0] a,
                          input logic [2:0] w, input logic [2:0] lg,
                          input logic req_mid);
        int k;
        int n;
        lag = lg;
        rd_space = sp;
        rd_addr = a;
        rd_wait = w;
        rd_req = 1'b1;
        k = 0;
        while (rd_ready !== 1'b1 && k < 200) begin
            step(1);
            k++;
        end
        step(1);
        rd_req = 1'b0;
        // Setup quarter: address and select out, strobe still high
        check("sel_setup", sel_n, 3'h7 ^ (3'h1 << sp));
        check("addr_setup", addr_out, a);
        check("strobe_setup", read_strobe_n, 1);
        step(1);
        check("strobe_fall", read_strobe_n, 0);
        check("strobe_q", processor_clock_out, 1);
        if (req_mid) bus_request_n = 1'b0;
        n = 1;
        while (read_strobe_n === 1'b0 && n < 40) begin
            step(1);
            if (read_strobe_n === 1'b0) n++;
        end
        check("strobe_len", n, 2 + 4 * w);
        check("done", rd_done, 1);
        check("data", rd_data, {6'h28, sp, 2'h0, a});
        check("sel_hold", sel_n, 3'h7 ^ (3'h1 << sp));
        check("addr_hold", addr_out, a);
        step(1);
        check("sel_idle", sel_n, 3'h7);
        $display("test read space %0d wait %0d done", sp, w);
    endtask

    task automatic t_grant(input logic lat);
        int k;
        bus_request_n = 1'b0;
        k = 0;
        while (strobe_oe_n !== 1'b1 && k < 60) begin
            step(1);
            k++;
        end
        // Sync, sample at quarter one, float at the next quarter zero
        if (lat) check("float_lat", k >= 5 && k <= 9, 1);
        check("grant_late", bus_grant_n, 1);
        check("float_q", processor_clock_out, 1);
        step(1);
        check("grant_low", bus_grant_n, 0);
        rd_req = 1'b1;
        step(20);
        check("grant_hold", bus_grant_n, 0);
        check("no_ready", rd_ready, 0);
        check("still_float", strobe_oe_n, 1);
        rd_req = 1'b0;
        bus_request_n = 1'b1;
        k = 0;
        while (bus_grant_n !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        check("oe_at_release", strobe_oe_n, 1);
        step(1);
        check("redriven", strobe_oe_n, 0);
        check("redrive_q", processor_clock_out, 1);
        check("strobes_idle", {read_strobe_n, sel_n}, 4'hf);
        $display("test grant done");
    endtask

    initial begin
        step(1);
        t_reset();
        for (int s = 0; s < 3; s++) begin
            t_read(s[1:0], 14'h3fff - 14'(s), 3'h0, 3'h1, 1'b0);
        end
        t_read(2'h1, 14'h0000, 3'h7, 3'h5, 1'b0);
        t_read(2'h0, 14'h1555, 3'h1, 3'h5, 1'b0);
        t_read(2'h2, 14'h2aaa, 3'h0, 3'h0, 1'b0);
        check("strobe_gap", min_gap >= 2, 1);
        t_grant(1'b1);
        t_read(2'h1, 14'h0123, 3'h3, 3'h2, 1'b1);
        t_grant(1'b0);
        t_reset();
        t_read(2'h2, 14'h0abc, 3'h2, 3'h1, 1'b0);
        end_of_test();
    end
endmodule // test_ext_mem_read_bus_grant
